// ### verilog/asbp_host.sv
// Host controller that drives an asynchronous 64K x 16 static memory.
//
// Overview of operation
// - Data setup/hold versus the ending strobe.
// - Never drive pins while device drives.
// - Write strobe high throughout every read.
// - Address valid before select falls.
`timescale 1ns/100ps
module asbp_host
  import asbp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_lane_i,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   chip_sel_n_o,
  output logic                   write_strobe_n_o,
  output logic                   out_gate_n_o,
  output logic                   upper_byte_sel_n_o,
  output logic                   lower_byte_sel_n_o,
  input  wire logic [DATA_W-1:0] mem_data_i,
  output logic [DATA_W-1:0]      mem_data_o,
  output logic                   mem_data_oe_o
);
  // ==========================================================================
  // State and registered pins
  asbp_state_t state;
  asbp_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [1:0] lane_n;
  logic       active;
  logic       wstrobe;
  logic       gate;
  logic       drive;

  // The counter times the read, turnaround and write phases; it reloads on entry to each of them.
  wire cnt_done = (cnt == '0);
  wire take     = (state == ASBP_IDLE) && req_valid_i && (req_lane_i != 2'h0);
  assign req_ready_o = (state == ASBP_IDLE);

  // A read holds its selects off for the first cycle of the phase, so the
  // address has a whole clock to settle before chip select falls. The phase
  // is one count longer, which keeps the selected time at the full read cycle.
  wire rd_hold = (state == ASBP_READ) && (next_state == ASBP_READ);

  // Next-state logic; every phase length is a least time, rounded up.
  always_comb begin
    next_state = state;
    next_cnt   = cnt_done ? cnt : cnt - 4'h1;
    case (state)
      ASBP_IDLE: begin
        if (take && req_write_i) begin
          next_state = ASBP_WTURN;
          next_cnt   = CNT_W'(TURN_CYC - 1);
        end else if (take) begin
          next_state = ASBP_READ;
          next_cnt   = CNT_W'(READ_CYC); // One extra count for the address lead.
        end
      end
      ASBP_READ: begin
        if (cnt_done) begin
          next_state = ASBP_RTURN;
          next_cnt   = CNT_W'(TURN_CYC - 1);
        end
      end
      ASBP_WTURN: begin
        if (cnt_done) begin
          next_state = ASBP_WRITE;
          next_cnt   = CNT_W'(WRITE_CYC - 1);
        end
      end
      ASBP_WRITE: begin
        if (cnt_done) begin
          next_state = ASBP_WEND;
        end
      end
      ASBP_WEND: begin
        next_state = ASBP_IDLE;
      end
      ASBP_RTURN: begin
        if (cnt_done) begin
          next_state = ASBP_IDLE;
        end
      end
      default: begin
        next_state = ASBP_IDLE;
      end
    endcase
  end

  // Pin control. Address is set while all strobes are high, so it leads them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= ASBP_IDLE;
      cnt     <= '0;
      lane_n  <= 2'h3;
      active  <= 1'b0;
      wstrobe <= 1'b0;
      gate    <= 1'b0;
      drive   <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      // Selects fall with the strobes, one cycle after the address is set for a read and TURN_CYC cycles after it for a write.
      active  <= rd_hold || (next_state == ASBP_WRITE);
      // The write strobe is low only in the write phase and never in a read.
      wstrobe <= (next_state == ASBP_WRITE);
      gate    <= rd_hold;
      // Data is driven only after the device has turned its pins off, and it
      // is held one cycle past the strobe rise for hold margin.
      drive   <= (next_state == ASBP_WRITE) || (next_state == ASBP_WEND);
      if (take) begin
        lane_n <= ~req_lane_i;
      end
    end
  end

  // Address and write data registers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_o <= '0;
      mem_data_o <= '0;
    end else if (take) begin
      mem_addr_o <= req_addr_i;
      mem_data_o <= req_wdata_i;
    end
  end

  // All strobes rise together, so the write ends on the one same edge.
  assign chip_sel_n_o       = ~active;
  assign write_strobe_n_o   = ~wstrobe;
  assign out_gate_n_o       = ~gate;
  assign upper_byte_sel_n_o = active ? lane_n[1] : 1'b1;
  assign lower_byte_sel_n_o = active ? lane_n[0] : 1'b1;
  assign mem_data_oe_o      = drive;

  // Read data is captured at the end of the read cycle for enabled lanes only.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= (state == ASBP_READ) && cnt_done;
      if ((state == ASBP_READ) && cnt_done) begin
        rsp_rdata_o <= {lane_n[1] ? 8'h00 : mem_data_i[15:8],
                        lane_n[0] ? 8'h00 : mem_data_i[7:0]};
      end
    end
  end

  // ==========================================================================
  // Assertions
  AST_NO_CLASH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mem_data_oe_o |-> out_gate_n_o)
    else $error("Host drives data while output gate is low");
  AST_WE_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !out_gate_n_o |-> write_strobe_n_o)
    else $error("Write strobe low during a read");
  AST_ADDR_LEAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(chip_sel_n_o) |-> $stable(mem_addr_o))
    else $error("Address changed as chip select fell");
  AST_WR_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(write_strobe_n_o) |-> !write_strobe_n_o[*8] ##1 write_strobe_n_o)
    else $error("Write pulse length wrong");
  AST_SETUP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(write_strobe_n_o) |-> $past(mem_data_oe_o) && mem_data_oe_o)
    else $error("Data not held across write end");
  AST_END_TOG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(write_strobe_n_o) |-> chip_sel_n_o && upper_byte_sel_n_o && lower_byte_sel_n_o)
    else $error("Strobes did not end the write together");
  AST_RD_RSP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(out_gate_n_o) |-> ##9 rsp_valid_o)
    else $error("Read response not on time");
  AST_TURN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(out_gate_n_o) |-> !mem_data_oe_o[*4])
    else $error("Bus turnaround too short");

  // Bus ownership: the host drives the data pins only when the device cannot.
  AST_WE_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !write_strobe_n_o |-> out_gate_n_o)
    else $error("Output gate low during a write");
  AST_DRIVE_LEAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(mem_data_oe_o) |-> out_gate_n_o && $past(out_gate_n_o, 4))
    else $error("Host drove data too soon after a read");
  AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_ready_o |-> chip_sel_n_o && write_strobe_n_o && !mem_data_oe_o)
    else $error("Pins not quiet while idle");

  // Strobe and address sequencing.
  AST_ADDR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !chip_sel_n_o |-> $stable(mem_addr_o))
    else $error("Address moved while the chip was selected");
  AST_DATA_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !write_strobe_n_o |-> mem_data_oe_o && $stable(mem_data_o))
    else $error("Write data not standing during the write pulse");
  AST_SEL_IN_CS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(upper_byte_sel_n_o && lower_byte_sel_n_o) |-> !chip_sel_n_o)
    else $error("Byte select low without chip select");
  AST_GATE_CS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !out_gate_n_o |-> !chip_sel_n_o)
    else $error("Output gate low without chip select");
  AST_RD_WE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(out_gate_n_o) |-> write_strobe_n_o[*8])
    else $error("Write strobe fell inside a read cycle");
  AST_RSP_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("Read response longer than one cycle");
endmodule : asbp_host

// ### verilog/asbp_pkg.sv
// Package with constants for the asynchronous static memory host controller.
package asbp_pkg;
  // ==========================================================================
  // Geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // ==========================================================================
  // Timing in nanoseconds and the clock period
  localparam int CLK_PERIOD_NS = 8;
  localparam int READ_CYCLE_NS = 70;
  localparam int WRITE_PULSE_NS = 60;
  localparam int DATA_SETUP_NS = 35;
  localparam int BUS_TURN_NS = 25;
  // Least times round up to whole cycles.
  localparam int READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // ==========================================================================
  // Controller states
  typedef enum logic [2:0] {
    ASBP_IDLE,
    ASBP_READ,
    ASBP_WTURN,
    ASBP_WRITE,
    ASBP_WEND,
    ASBP_RTURN
  } asbp_state_t;
endpackage : asbp_pkg

// ### bench/asbp_sram_model.sv
// Behavioural model of the 64K x 16 static memory on the controller's far side.
`timescale 1ns/100ps
module asbp_sram_model
  import asbp_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              chip_sel_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic              out_gate_n_i,
  input  wire logic              upper_byte_sel_n_i,
  input  wire logic              lower_byte_sel_n_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic      [1:0]        lane_oe_o
);
  // ==========================================================================
  // Storage and strobe decoding
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire  any_lane = !(upper_byte_sel_n_i && lower_byte_sel_n_i);
  wire  wr       = !chip_sel_n_i && !write_strobe_n_i && any_lane;
  wire  rd       = !chip_sel_n_i && write_strobe_n_i && !out_gate_n_i;
  // Stores while the strobes overlap, so whichever strobe rises first ends it.
  always @* begin
    if (wr && !lower_byte_sel_n_i) mem[addr_i][7:0] = data_i[7:0];
    if (wr && !upper_byte_sel_n_i) mem[addr_i][15:8] = data_i[15:8];
  end
  // Output follows the address with no strobe toggling.
  assign data_o    = mem[addr_i];
  assign lane_oe_o = {rd && !upper_byte_sel_n_i, rd && !lower_byte_sel_n_i};
endmodule : asbp_sram_model

// ### bench/asbp_host_tb.sv
// Self-checking testbench of the static memory host controller.
`timescale 1ns/100ps
module asbp_host_tb;
  import asbp_pkg::*;
  typedef struct {logic w; logic [15:0] a; logic [15:0] d; logic [1:0] l;} asbp_row_t;
  logic clk_i, rst_n_i, req_valid_i, req_write_i;
  logic clash = 1'b0;
  logic [15:0] req_addr_i, req_wdata_i, mem_addr_o, mem_data_o, rsp_rdata_o, dev_d;
  wire  [15:0] mem_data_i;
  logic [1:0] req_lane_i, dev_oe;
  logic req_ready_o, rsp_valid_o, cs_n, we_n, oe_n, ub_n, lb_n, mem_data_oe_o;
  int fails = 0, n_compared = 0;
  // Rows: write flag, address, data to write or data expected back, lanes.
  asbp_row_t rows [8] = '{'{1, 16'h1234, 16'hA5C3, 2'h3}, '{0, 16'h1234, 16'hA5C3, 2'h3},
    '{1, 16'h1234, 16'hFF77, 2'h1}, '{0, 16'h1234, 16'hA577, 2'h3},
    '{0, 16'h1234, 16'hA500, 2'h2}, '{0, 16'h1234, 16'h0077, 2'h1},
    '{1, 16'hFFFF, 16'h1E2D, 2'h2}, '{0, 16'hFFFF, 16'h1E00, 2'h2}};
  // ==========================================================================
  // Wire level: a released line shows the inverse of the host's last value.
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign mem_data_i[g*8+:8] = mem_data_oe_o ? mem_data_o[g*8+:8] :
                                dev_oe[g] ? dev_d[g*8+:8] : ~mem_data_o[g*8+:8];
  end
  asbp_host asbp_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_lane_i(req_lane_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o), .chip_sel_n_o(cs_n),
    .write_strobe_n_o(we_n), .out_gate_n_o(oe_n), .upper_byte_sel_n_o(ub_n),
    .lower_byte_sel_n_o(lb_n), .mem_data_i(mem_data_i), .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o));
  asbp_sram_model asbp_sram_model_inst (.addr_i(mem_addr_o), .chip_sel_n_i(cs_n),
    .write_strobe_n_i(we_n), .out_gate_n_i(oe_n), .upper_byte_sel_n_i(ub_n),
    .lower_byte_sel_n_i(lb_n), .data_i(mem_data_i), .data_o(dev_d), .lane_oe_o(dev_oe));
  // Sticky flag: a write with the gate low, or both sides driving the pins.
  always @(posedge clk_i)
    if (rst_n_i && ((!cs_n && !we_n && !oe_n) || (mem_data_oe_o && |dev_oe))) clash <= 1'b1;
  // ==========================================================================
  // Clock, compare and closing tasks
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // One request; reads wait a bounded time for the answer and compare it.
  task automatic do_op(input asbp_row_t r);
    int k;
    int seen;
    seen = 0;
    @(posedge clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_lane_i} <= {1'b1, r.w, r.a, r.d, r.l};
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    // Look a step after each edge, once the registered outputs have settled.
    #1;
    for (k = 0; k < 30 && req_ready_o !== 1'b1; k++) begin
      if (rsp_valid_o === 1'b1) begin
        seen++;
        chk(rsp_rdata_o, r.d);
      end
      @(posedge clk_i);
      #1;
    end
    chk(16'(seen), {15'h0, !r.w});
    chk({15'h0, req_ready_o}, 16'h0001);
  endtask : do_op
  // ==========================================================================
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    {rst_n_i, req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_lane_i} = '0;
    repeat (5) @(posedge clk_i);
    chk({11'h0, cs_n, we_n, oe_n, ub_n, lb_n}, 16'h001F);
    rst_n_i <= 1'b1;
    foreach (rows[i]) do_op(rows[i]);
    // A request with no lane enabled must never start a cycle.
    @(posedge clk_i);
    {req_valid_i, req_write_i, req_lane_i} <= {1'b1, 1'b1, 2'h0};
    repeat (4) @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
    chk({14'h0, cs_n, req_ready_o}, 16'h0003);
    // Reset in mid-write: every strobe rises at once, the bus is let go,
    // and a read must work right after release.
    @(posedge clk_i);
    {req_valid_i, req_write_i, req_lane_i} <= {1'b1, 1'b1, 2'h3};
    {req_addr_i, req_wdata_i} <= {16'h0042, 16'h5AA5};
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk({15'h0, we_n}, 16'h0000);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    #1;
    chk({10'h0, mem_data_oe_o, cs_n, we_n, oe_n, ub_n, lb_n}, 16'h001F);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    do_op(rows[3]);
    chk({15'h0, clash}, 16'h0000);
    test_done();
  end
  // Watchdog: the whole sequence needs well under 400 cycles.
  initial begin
    repeat (2000) @(posedge clk_i);
    fails++;
    test_done();
  end
endmodule : asbp_host_tb
